/* logic/pieb_top.sv */
// peripheral interrupt enable banks 2 to 4 with flags and gating
//
// The plain strobed port and the register offsets are this design's own decisions.
module pieb_top (
   input  wire logic                           mclk,        // system clock
   input  wire logic                           rst_n,       // async reset
   input  wire logic [pieb_pkg::ADDR_W-1:0]    addr,        // register addr
   input  wire logic [pieb_pkg::DATA_W-1:0]    wdata,       // write data
   input  wire logic                           wr_en,       // write strobe
   input  wire logic                           rd_en,       // read strobe
   input  wire logic [pieb_pkg::DATA_W-1:0]    bank2_event, // bank 2 events
   input  wire logic [pieb_pkg::DATA_W-1:0]    bank3_event, // bank 3 events
   input  wire logic [pieb_pkg::DATA_W-1:0]    bank4_event, // bank 4 events
   output logic      [pieb_pkg::DATA_W-1:0]    rdata,       // read data
   output logic                                irq_request  // core request
);
   import pieb_pkg::*;

   localparam int BANK3_BASE = DATA_W;
   localparam int BANK4_BASE = 2 * DATA_W;
   localparam int ALL_W      = 3 * DATA_W;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic              wr_enable2;
   logic              wr_enable3;
   logic              wr_enable4;
   logic              wr_flag2;
   logic              wr_flag3;
   logic              wr_flag4;
   logic              wr_ctrl;
   logic [DATA_W-1:0] enable2;
   logic [DATA_W-1:0] enable3;
   logic [DATA_W-1:0] enable4;
   logic [DATA_W-1:0] flag2;
   logic [DATA_W-1:0] flag3;
   logic [DATA_W-1:0] flag4;
   logic [DATA_W-1:0] active2;
   logic [DATA_W-1:0] active3;
   logic [DATA_W-1:0] active4;
   logic              any_active;
   logic              global_gate;
   logic              periph_gate;
   logic [DATA_W-1:0] next_rdata;
   logic [ALL_W-1:0]  all_en;
   logic [ALL_W-1:0]  all_fl;
   logic [ALL_W-1:0]  all_act;

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   always_comb begin
      wr_enable2 = wr_en && (addr == ADDR_ENABLE2);
      wr_enable3 = wr_en && (addr == ADDR_ENABLE3);
      wr_enable4 = wr_en && (addr == ADDR_ENABLE4);
      wr_flag2   = wr_en && (addr == ADDR_FLAG2);
      wr_flag3   = wr_en && (addr == ADDR_FLAG3);
      wr_flag4   = wr_en && (addr == ADDR_FLAG4);
      wr_ctrl    = wr_en && (addr == ADDR_CTRL);
   end

   // ----------------------------------------------------------------
   // banks
   // ----------------------------------------------------------------
   // bank 2: all eight positions carry a source
   pieb_bank #(
      .WIDTH (DATA_W),
      .MASK  (BANK2_MASK)
   ) u_bank2 (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .en_wr    (wr_enable2),
      .fl_wr    (wr_flag2),
      .wdata    (wdata),
      .event_in (bank2_event),
      .enable   (enable2),
      .flag     (flag2),
      .active   (active2)
   );

   pieb_bank #(
      .WIDTH (DATA_W),
      .MASK  (BANK3_MASK)
   ) u_bank3 (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .en_wr    (wr_enable3),
      .fl_wr    (wr_flag3),
      .wdata    (wdata),
      .event_in (bank3_event),
      .enable   (enable3),
      .flag     (flag3),
      .active   (active3)
   );

   pieb_bank #(
      .WIDTH (DATA_W),
      .MASK  (BANK4_MASK)
   ) u_bank4 (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .en_wr    (wr_enable4),
      .fl_wr    (wr_flag4),
      .wdata    (wdata),
      .event_in (bank4_event),
      .enable   (enable4),
      .flag     (flag4),
      .active   (active4)
   );

   assign all_en     = {enable4, enable3, enable2};
   assign all_fl     = {flag4, flag3, flag2};
   assign all_act    = {active4, active3, active2};
   assign any_active = |all_act;

   // ----------------------------------------------------------------
   // gates and request
   // ----------------------------------------------------------------
   pieb_gate u_gate (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .ctrl_wr     (wr_ctrl),
      .wdata       (wdata),
      .any_active  (any_active),
      .global_gate (global_gate),
      .periph_gate (periph_gate),
      .irq_request (irq_request)
   );

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // data stand one cycle only; idle and unmapped reads return zero
   always_comb begin
      next_rdata = '0;
      if (rd_en) begin
         case (addr)
            ADDR_ENABLE2: next_rdata = enable2;
            ADDR_ENABLE3: next_rdata = enable3;
            ADDR_ENABLE4: next_rdata = enable4;
            ADDR_FLAG2:   next_rdata = flag2;
            ADDR_FLAG3:   next_rdata = flag3;
            ADDR_FLAG4:   next_rdata = flag4;
            ADDR_CTRL: begin
               next_rdata[GLOBAL_GATE_POS] = global_gate;
               next_rdata[PERIPH_GATE_POS] = periph_gate;
               next_rdata[PENDING_POS]     = any_active;
            end
            default:      next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_gates_open;
      global_gate && periph_gate;
   endsequence

   sequence s_bus_write(logic [ADDR_W-1:0] a);
      wr_en && (addr == a);
   endsequence

   // one source: set enable lets its flag through, clear one stops it
   property p_bit(int i);
      @(posedge mclk) disable iff (!rst_n)
         ((s_gates_open and (all_en[i] && all_fl[i])) |=> irq_request)
         and
         ((!all_en[i] && ((all_act & ~(ALL_W'(1) << i)) == '0))
            |=> !irq_request);
   endproperty

   property p_write_back(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] m,
                         logic [DATA_W-1:0] r);
      @(posedge mclk) disable iff (!rst_n)
         s_bus_write(a) ##1 (!wr_en && !rd_en)
            ##1 (!wr_en && rd_en && addr == a)
            |=> (rdata == ($past(wdata, 3) & m)) && ((r & ~m) == '0);
   endproperty

   osc_bit_a: assert property (p_bit(OSC_FAIL_POS))
      else $error("oscillator fail enable misbehaves");
   comp2_bit_a: assert property (p_bit(COMP_TWO_POS))
      else $error("comparator two enable misbehaves");
   comp1_bit_a: assert property (p_bit(COMP_ONE_POS))
      else $error("comparator one enable misbehaves");
   nvdata_bit_a: assert property (p_bit(NVDATA_POS))
      else $error("write completion enable misbehaves");
   ser1_coll_a: assert property (p_bit(SER1_COLL_POS))
      else $error("serial one collision enable misbehaves");
   seg_disp_a: assert property (p_bit(SEG_DISP_POS))
      else $error("segment display enable misbehaves");
   comp3_bit_a: assert property (p_bit(COMP_THREE_POS))
      else $error("comparator three enable misbehaves");
   capcomp2_bit_a: assert property (p_bit(CAPCOMP_TWO_POS))
      else $error("capture two enable misbehaves");
   capcomp5_bit_a: assert property (
      p_bit(BANK3_BASE + CAPCOMP_FIVE_POS))
      else $error("capture five enable misbehaves");
   capcomp4_bit_a: assert property (
      p_bit(BANK3_BASE + CAPCOMP_FOUR_POS))
      else $error("capture four enable misbehaves");
   capcomp3_bit_a: assert property (
      p_bit(BANK3_BASE + CAPCOMP_THR_POS))
      else $error("capture three enable misbehaves");
   timer6_bit_a: assert property (
      p_bit(BANK3_BASE + TIMER_SIX_POS))
      else $error("timer six enable misbehaves");
   timer4_bit_a: assert property (
      p_bit(BANK3_BASE + TIMER_FOUR_POS))
      else $error("timer four enable misbehaves");
   uart_rx_a: assert property (p_bit(BANK4_BASE + UART2_RX_POS))
      else $error("uart two receive enable misbehaves");
   uart_tx_a: assert property (p_bit(BANK4_BASE + UART2_TX_POS))
      else $error("uart two transmit enable misbehaves");
   ser2_coll_a: assert property (p_bit(BANK4_BASE + SER2_COLL_POS))
      else $error("serial two collision enable misbehaves");
   ser2_xfer_a: assert property (p_bit(BANK4_BASE + SER2_XFER_POS))
      else $error("serial two transfer enable misbehaves");

   bank3_zero_a: assert property (
      p_write_back(ADDR_ENABLE3, BANK3_MASK, enable3))
      else $error("bank three unimplemented bit holds data");
   bank4_zero_a: assert property (
      p_write_back(ADDR_ENABLE4, BANK4_MASK, enable4))
      else $error("bank four unimplemented bit holds data");
   bank2_rw_a: assert property (
      p_write_back(ADDR_ENABLE2, BANK2_MASK, enable2))
      else $error("bank two enable did not store write");

   reset_clear_a: assert property (
      @(posedge mclk) $rose(rst_n)
         |-> (all_en == '0) && (all_fl == '0) && !irq_request)
      else $error("enables not clear after reset");

   flag_set_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
         (bank2_event != '0)
            |=> ((flag2 & $past(bank2_event)) == $past(bank2_event)))
      else $error("event did not set its pending flag");

   periph_block_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
         !periph_gate |=> !irq_request)
      else $error("request with peripheral gate clear");

   global_block_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
         !global_gate [*2] |-> ##1 !irq_request)
      else $error("request with global gate clear");

   request_cause_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
         irq_request |-> $past(global_gate && periph_gate && any_active))
      else $error("request without a gated active source");

   request_rise_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
         (s_gates_open and any_active) |=> irq_request)
      else $error("active gated source raised no request");

   // ----------------------------------------------------------------
   // register and flag checks
   // ----------------------------------------------------------------
   // a write lands at its own edge with only implemented bits kept
   property p_enable_write(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] m,
                           logic [DATA_W-1:0] r);
      @(posedge mclk) disable iff (!rst_n)
         s_bus_write(a) |=> (r == ($past(wdata) & m));
   endproperty

   // event ored over the written value: a set beats a clear
   property p_flag_write(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] m,
                         logic [DATA_W-1:0] e, logic [DATA_W-1:0] f);
      @(posedge mclk) disable iff (!rst_n)
         s_bus_write(a) |=> (f == (($past(wdata) | $past(e)) & m));
   endproperty

   property p_flag_set(logic [DATA_W-1:0] m, logic [DATA_W-1:0] e,
                       logic [DATA_W-1:0] f);
      @(posedge mclk) disable iff (!rst_n)
         ((e & m) != '0) |=> ((f & $past(e) & m) == ($past(e) & m));
   endproperty

   // read data mirror the register and show zero where nothing is stored
   property p_read_back(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] m,
                        logic [DATA_W-1:0] r);
      @(posedge mclk) disable iff (!rst_n)
         (rd_en && addr == a)
            |=> (rdata == $past(r)) && ((rdata & ~m) == '0);
   endproperty

   en2_write_a: assert property (
      p_enable_write(ADDR_ENABLE2, BANK2_MASK, enable2))
      else $error("bank two enable write lost");
   en3_write_a: assert property (
      p_enable_write(ADDR_ENABLE3, BANK3_MASK, enable3))
      else $error("bank three enable write lost");
   en4_write_a: assert property (
      p_enable_write(ADDR_ENABLE4, BANK4_MASK, enable4))
      else $error("bank four enable write lost");

   fl2_write_a: assert property (
      p_flag_write(ADDR_FLAG2, BANK2_MASK, bank2_event, flag2))
      else $error("bank two flag write wrong");
   fl3_write_a: assert property (
      p_flag_write(ADDR_FLAG3, BANK3_MASK, bank3_event, flag3))
      else $error("bank three flag write wrong");
   fl4_write_a: assert property (
      p_flag_write(ADDR_FLAG4, BANK4_MASK, bank4_event, flag4))
      else $error("bank four flag write wrong");

   flag_set3_a: assert property (
      p_flag_set(BANK3_MASK, bank3_event, flag3))
      else $error("bank three event did not set its flag");
   flag_set4_a: assert property (
      p_flag_set(BANK4_MASK, bank4_event, flag4))
      else $error("bank four event did not set its flag");

   enable_hold_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
         !wr_en |=> $stable(all_en))
      else $error("enable changed without a write");

   flag_hold_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
         (!wr_en && ((bank2_event | bank3_event | bank4_event) == '0))
            |=> $stable(all_fl))
      else $error("flag changed without a write or event");

   rdata_idle_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
         !rd_en |=> (rdata == '0))
      else $error("read data stood past its cycle");

   rd_en2_a: assert property (
      p_read_back(ADDR_ENABLE2, BANK2_MASK, enable2))
      else $error("bank two enable read wrong");
   rd_en3_a: assert property (
      p_read_back(ADDR_ENABLE3, BANK3_MASK, enable3))
      else $error("bank three enable read wrong");
   rd_en4_a: assert property (
      p_read_back(ADDR_ENABLE4, BANK4_MASK, enable4))
      else $error("bank four enable read wrong");

   gate_write_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
         s_bus_write(ADDR_CTRL)
            |=> (global_gate == $past(wdata[GLOBAL_GATE_POS]))
               && (periph_gate == $past(wdata[PERIPH_GATE_POS])))
      else $error("gate write did not land");

   request_fall_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
         !any_active |=> !irq_request)
      else $error("request held with no active source");
endmodule : pieb_top

/* pkg/pieb_pkg.sv */
// constants shared by the peripheral interrupt enable bank design
package pieb_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_ENABLE2 = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE3 = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE4 = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_FLAG2   = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_FLAG3   = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_FLAG4   = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_CTRL    = 4'h6;

   // ----------------------------------------------------------------
   // implemented bits and reset values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] BANK2_MASK  = 8'hff;
   localparam logic [DATA_W-1:0] BANK3_MASK  = 8'h7a;
   localparam logic [DATA_W-1:0] BANK4_MASK  = 8'h33;
   localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int OSC_FAIL_POS     = 7;
   localparam int COMP_TWO_POS     = 6;
   localparam int COMP_ONE_POS     = 5;
   localparam int NVDATA_POS       = 4;
   localparam int SER1_COLL_POS    = 3;
   localparam int SEG_DISP_POS     = 2;
   localparam int COMP_THREE_POS   = 1;
   localparam int CAPCOMP_TWO_POS  = 0;
   localparam int CAPCOMP_FIVE_POS = 6;
   localparam int CAPCOMP_FOUR_POS = 5;
   localparam int CAPCOMP_THR_POS  = 4;
   localparam int TIMER_SIX_POS    = 3;
   localparam int TIMER_FOUR_POS   = 1;
   localparam int UART2_RX_POS     = 5;
   localparam int UART2_TX_POS     = 4;
   localparam int SER2_COLL_POS    = 1;
   localparam int SER2_XFER_POS    = 0;
   localparam int GLOBAL_GATE_POS  = 7;
   localparam int PERIPH_GATE_POS  = 6;
   localparam int PENDING_POS      = 0;
endpackage : pieb_pkg

/* logic/pieb_bank.sv */
// one enable register with its matching pending flag register
module pieb_bank #(
   parameter int               WIDTH = 8,
   parameter logic [WIDTH-1:0] MASK  = '1
) (
   input  wire logic             mclk,     // system clock
   input  wire logic             rst_n,    // async reset, active low
   input  wire logic             en_wr,    // write the enable register
   input  wire logic             fl_wr,    // write the flag register
   input  wire logic [WIDTH-1:0] wdata,    // write data
   input  wire logic [WIDTH-1:0] event_in, // source event pulses
   output logic      [WIDTH-1:0] enable,   // enable bits
   output logic      [WIDTH-1:0] flag,     // pending flags
   output logic      [WIDTH-1:0] active    // flag and enable both set
);
   logic [WIDTH-1:0] next_enable;
   logic [WIDTH-1:0] next_flag;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_enable = en_wr ? (wdata & MASK) : enable;
      // event ored in last: a set beats a clear in the same cycle
      next_flag = (fl_wr ? wdata : flag) | event_in;
      next_flag = next_flag & MASK;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         enable <= '0;
         flag   <= '0;
      end else begin
         enable <= next_enable;
         flag   <= next_flag;
      end
   end

   assign active = flag & enable;
endmodule : pieb_bank

/* logic/pieb_gate.sv */
// core gate bits and the registered processor interrupt request
module pieb_gate
   import pieb_pkg::*;
(
   input  wire logic              mclk,        // system clock
   input  wire logic              rst_n,       // async reset, active low
   input  wire logic              ctrl_wr,     // write the gate register
   input  wire logic [DATA_W-1:0] wdata,       // write data
   input  wire logic              any_active,  // some source flagged+enabled
   output logic                   global_gate, // global gate bit
   output logic                   periph_gate, // peripheral gate bit
   output logic                   irq_request  // request to the core
);
   logic next_global;
   logic next_periph;
   logic next_irq;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_global = ctrl_wr ? wdata[GLOBAL_GATE_POS] : global_gate;
      next_periph = ctrl_wr ? wdata[PERIPH_GATE_POS] : periph_gate;
      // every source here is a peripheral, so both gates apply
      next_irq = global_gate & periph_gate & any_active;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         global_gate <= 1'b0;
         periph_gate <= 1'b0;
         irq_request <= 1'b0;
      end else begin
         global_gate <= next_global;
         periph_gate <= next_periph;
         irq_request <= next_irq;
      end
   end
endmodule : pieb_gate

/* dv/pieb_src_model.sv */
// event source model standing in for the on-chip peripheral sources
module pieb_src_model (
   input  wire logic                        mclk,  // system clock
   input  wire logic                        rst_n, // async reset, active low
   input  wire logic                        fire,  // launch one event pulse
   input  wire logic [1:0]                  bank,  // 0 bank2, 1 bank3, 2 bank4
   input  wire logic [pieb_pkg::DATA_W-1:0] bits,  // sources that fire
   output logic      [pieb_pkg::DATA_W-1:0] ev2,   // bank 2 event pulses
   output logic      [pieb_pkg::DATA_W-1:0] ev3,   // bank 3 event pulses
   output logic      [pieb_pkg::DATA_W-1:0] ev4    // bank 4 event pulses
);
   timeunit 1ns;
   timeprecision 1ps;
   import pieb_pkg::*;
   logic [DATA_W-1:0] next_ev2;
   logic [DATA_W-1:0] next_ev3;
   logic [DATA_W-1:0] next_ev4;

   // sources pulse for one cycle; idle lines are genuinely low
   always_comb begin
      next_ev2 = (fire && bank == 2'd0) ? bits : 8'h00;
      next_ev3 = (fire && bank == 2'd1) ? bits : 8'h00;
      next_ev4 = (fire && bank == 2'd2) ? bits : 8'h00;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ev2 <= 8'h00;
         ev3 <= 8'h00;
         ev4 <= 8'h00;
      end else begin
         ev2 <= next_ev2;
         ev3 <= next_ev3;
         ev4 <= next_ev4;
      end
   end
endmodule : pieb_src_model

/* dv/pieb_top_tb.sv */
// self-checking bench for the peripheral interrupt enable banks
module pieb_top_tb
   import pieb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              mclk;
   logic              rst_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr_en;
   logic              rd_en;
   logic [DATA_W-1:0] ev2, ev3, ev4;
   logic [DATA_W-1:0] rdata;
   logic              irq_request;
   logic              fire;
   logic [1:0]        fbank;
   logic [DATA_W-1:0] fbits;
   int                fail_count;
   int                n_tests;
   int                cycles = 0;

   pieb_top dut_u (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .bank2_event(ev2), .bank3_event(ev3),
      .bank4_event(ev4), .rdata(rdata), .irq_request(irq_request));

   pieb_src_model src_u (.mclk(mclk), .rst_n(rst_n), .fire(fire),
      .bank(fbank), .bits(fbits), .ev2(ev2), .ev3(ev3), .ev4(ev4));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ----------------------------------------------------------------
   // bus, event and compare helpers
   // ----------------------------------------------------------------
   task automatic check(string name, logic [7:0] exp, logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : check

   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge mclk);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd_chk(logic [3:0] a, logic [7:0] exp, string name);
      @(posedge mclk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      check(name, exp, rdata);
   endtask : rd_chk

   task automatic fire_ev(logic [1:0] b, logic [7:0] v);
      @(posedge mclk);
      fire  <= 1'b1;
      fbank <= b;
      fbits <= v;
      @(posedge mclk);
      fire  <= 1'b0;
      @(posedge mclk);
   endtask : fire_ev

   task automatic irq_chk(logic exp);
      repeat (2) @(posedge mclk);
      #1;
      check("irq_request", {7'h00, exp}, {7'h00, irq_request});
   endtask : irq_chk

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_access();
      logic [3:0] ea [3];
      logic [3:0] fa [3];
      logic [7:0] mk [3];
      ea = '{ADDR_ENABLE2, ADDR_ENABLE3, ADDR_ENABLE4};
      fa = '{ADDR_FLAG2, ADDR_FLAG3, ADDR_FLAG4};
      mk = '{8'hff, 8'h7a, 8'h33};
      for (int b = 0; b < 3; b++) begin
         rd_chk(ea[b], 8'h00, "enable reset");
         wr(ea[b], 8'hff);
         rd_chk(ea[b], mk[b], "enable all ones");
         wr(ea[b], 8'ha5);
         rd_chk(ea[b], mk[b] & 8'ha5, "enable pattern");
         wr(ea[b], 8'h00);
         rd_chk(ea[b], 8'h00, "enable cleared");
         fire_ev(b[1:0], 8'hff);
         rd_chk(fa[b], mk[b], "flag all events");
         wr(fa[b], 8'h00);
      end
      wr(4'hf, 8'hff);
      rd_chk(4'hf, 8'h00, "unmapped read");
   endtask : t_access

   // an enable for every other source in the bank must not pass this source
   task automatic t_per_bit(logic [3:0] ea, logic [3:0] fa, logic [1:0] b,
                            logic [7:0] m);
      logic [7:0] bm;
      for (int i = 0; i < 8; i++) begin
         bm = 8'h01 << i;
         if ((m & bm) != 8'h00) begin
            wr(ea, m & ~bm);
            fire_ev(b, bm);
            rd_chk(fa, bm, "flag while disabled");
            irq_chk(1'b0);
            wr(ea, bm);
            irq_chk(1'b1);
            wr(fa, 8'h00);
            irq_chk(1'b0);
            wr(ea, 8'h00);
         end
      end
   endtask : t_per_bit

   task automatic t_gates();
      logic [7:0] g;
      wr(ADDR_ENABLE4, 8'h20);
      fire_ev(2'd2, 8'h20);
      for (int k = 0; k < 4; k++) begin
         g = {k[1:0], 6'h00};
         wr(ADDR_CTRL, g);
         irq_chk(g == 8'hc0);
         rd_chk(ADDR_CTRL, g | 8'h01, "gate register");
      end
   endtask : t_gates

   task automatic t_reset_mid();
      wr(ADDR_FLAG4, 8'h00);
      wr(ADDR_ENABLE2, 8'hff);
      wr(ADDR_ENABLE3, 8'hff);
      irq_chk(1'b0);
      fire_ev(2'd0, 8'h80);
      irq_chk(1'b1);
      @(posedge mclk);
      rst_n <= 1'b0;
      #1;
      check("irq in reset", 8'h00, {7'h00, irq_request});
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      rd_chk(ADDR_ENABLE2, 8'h00, "enable2 after reset");
      rd_chk(ADDR_ENABLE3, 8'h00, "enable3 after reset");
      rd_chk(ADDR_FLAG2, 8'h00, "flag2 after reset");
      rd_chk(ADDR_CTRL, 8'h00, "gates after reset");
   endtask : t_reset_mid

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   // the full run needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   initial begin
      rst_n = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      fire = 1'b0;
      fbank = 2'd0;
      fbits = 8'h00;
      fail_count = 0;
      n_tests = 0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      check("irq after reset", 8'h00, {7'h00, irq_request});
      t_access();
      wr(ADDR_CTRL, 8'hc0);
      t_per_bit(ADDR_ENABLE2, ADDR_FLAG2, 2'd0, 8'hff);
      t_per_bit(ADDR_ENABLE3, ADDR_FLAG3, 2'd1, 8'h7a);
      t_per_bit(ADDR_ENABLE4, ADDR_FLAG4, 2'd2, 8'h33);
      t_gates();
      t_reset_mid();
      summarize();
   end
endmodule : pieb_top_tb
